// ### core/sac_top.sv
module sac_top (
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [sac_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            irq,
   output logic                            converter_power,
   output logic                            converter_clk,
   output logic      [1:0]                 input_select,
   output logic                            sample_hold,
   output logic      [sac_pkg::RES_W-1:0]  trial_code,
   input  wire logic                       cmp_out
);

   logic [7:0]                cfg;
   logic [1:0]                sample_mean_count;
   logic                      soft_trigger;
   logic                      conversion_done_flag;
   logic [7:0]                result_low;
   logic [7:0]                result_high;
   logic [1:0]                irq_status;
   logic [1:0]                irq_mask;
   logic [sac_pkg::DIV_W-1:0] div_cnt;
   logic                      tick;
   logic                      cmp_meta;
   logic                      cmp_sync;
   sac_pkg::sac_state_e       state;
   logic [3:0]                bit_idx;
   logic [3:0]                samples;
   logic [sac_pkg::ACC_W-1:0] acc;
   logic [sac_pkg::RES_W-1:0] sar;
   logic [sac_pkg::RES_W-1:0] next_sar;
   logic [sac_pkg::ACC_W-1:0] next_acc;
   logic [sac_pkg::RES_W-1:0] mean;
   logic [15:0]               packed_res;
   logic [7:0]                addr_idx;
   logic                      addr_ok;
   logic                      setup_phase;
   logic                      wr_acc;
   logic                      rd_acc;
   logic                      snap_flag;
   logic [1:0]                snap_stat;
   logic                      sample_last;
   logic                      finish_ok;
   logic                      converter_on;
   logic                      done_irq_enable;
   logic                      justify_select;
   logic [2:0]                pre;

   function automatic logic [sac_pkg::DIV_W-1:0] div_mask(input logic [2:0] code);
      div_mask = sac_pkg::DIV_W'((9'h002 << code) - 9'h001);
   endfunction

   function automatic logic [15:0] pack_result(input logic [sac_pkg::RES_W-1:0] r,
                                                input logic                      msb_just);
      if (msb_just) begin
         pack_result = {r[10:3], r[2:0], 5'h00};
      end else begin
         pack_result = {5'h00, r[10:8], r[7:0]};
      end
   endfunction

   function automatic logic [3:0] mean_count(input logic [1:0] code);
      mean_count = 4'h1 << code;
   endfunction

   assign converter_on    = cfg[sac_pkg::CFG_ON_BIT];
   assign done_irq_enable = cfg[sac_pkg::CFG_IRQEN_BIT];
   assign justify_select  = cfg[sac_pkg::CFG_JUST_BIT];
   assign pre             = cfg[sac_pkg::CFG_PRE_LSB +: 3];

   // Bus decode: register index sits at byte address index times four.
   assign addr_idx    = paddr[9:2];
   assign addr_ok     = (paddr[1:0] == 2'h0) && (paddr[sac_pkg::ADDR_W-1:10] == 2'h0) &&
                        (addr_idx == sac_pkg::IDX_CONFIG   || addr_idx == sac_pkg::IDX_RES_LOW ||
                         addr_idx == sac_pkg::IDX_RES_HIGH || addr_idx == sac_pkg::IDX_CONTROL ||
                         addr_idx == sac_pkg::IDX_IRQ_STAT || addr_idx == sac_pkg::IDX_IRQ_MASK);
   assign setup_phase = psel && !penable;
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !addr_ok;
   assign wr_acc      = psel && penable && pwrite && addr_ok && pstrb[0];
   assign rd_acc      = psel && penable && !pwrite && addr_ok;

   // Read data is captured in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata    <= 32'h0000_0000;
         snap_flag <= 1'b0;
         snap_stat <= 2'h0;
      end else if (setup_phase && !pwrite) begin
         snap_flag <= conversion_done_flag;
         snap_stat <= irq_status;
         unique case (addr_idx)
            sac_pkg::IDX_CONFIG:   prdata <= {24'h000000, cfg};
            sac_pkg::IDX_RES_LOW:  prdata <= {24'h000000, result_low};
            sac_pkg::IDX_RES_HIGH: prdata <= {24'h000000, result_high};
            sac_pkg::IDX_CONTROL:  prdata <= {24'h000000, sample_mean_count, input_select,
                                              2'h0, conversion_done_flag, soft_trigger};
            sac_pkg::IDX_IRQ_STAT: prdata <= {30'h00000000, irq_status};
            sac_pkg::IDX_IRQ_MASK: prdata <= {30'h00000000, irq_mask};
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration and control fields written by software.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg               <= sac_pkg::CONFIG_RESET;
         sample_mean_count <= sac_pkg::CONTROL_RESET[sac_pkg::CTL_AVG_LSB +: 2];
         input_select      <= sac_pkg::CONTROL_RESET[sac_pkg::CTL_SEL_LSB +: 2];
         irq_mask          <= 2'h0;
      end else if (wr_acc) begin
         if (addr_idx == sac_pkg::IDX_CONFIG) begin
            cfg <= {pwdata[7:5], 2'h0, pwdata[2:0]};
         end
         if (addr_idx == sac_pkg::IDX_CONTROL) begin
            sample_mean_count <= pwdata[sac_pkg::CTL_AVG_LSB +: 2];
            input_select      <= pwdata[sac_pkg::CTL_SEL_LSB +: 2];
         end
         if (addr_idx == sac_pkg::IDX_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end

   assign finish_ok = (state == sac_pkg::SAC_FINISH) && !conversion_done_flag;

   // Start bit: set by software, cleared by hardware at the end or at power-down.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         soft_trigger <= 1'b0;
      end else if (!converter_on || state == sac_pkg::SAC_FINISH) begin
         soft_trigger <= 1'b0;
      end else if (wr_acc && addr_idx == sac_pkg::IDX_CONTROL &&
                   pwdata[sac_pkg::CTL_TRIG_BIT]) begin
         soft_trigger <= 1'b1;
      end
   end

   // Completion flag: a set in the same cycle as a low-byte read wins.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         conversion_done_flag <= 1'b0;
      end else if (finish_ok) begin
         conversion_done_flag <= 1'b1;
      end else if (rd_acc && addr_idx == sac_pkg::IDX_RES_LOW && snap_flag) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // Result bytes take a new value only while the flag is clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         result_low  <= 8'h00;
         result_high <= 8'h00;
      end else if (finish_ok) begin
         result_low  <= packed_res[7:0];
         result_high <= packed_res[15:8];
      end
   end

   // Sticky event bits, cleared by reading the status register.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_status <= 2'h0;
      end else begin
         irq_status <= (rd_acc && addr_idx == sac_pkg::IDX_IRQ_STAT) ?
                       (irq_status & ~snap_stat) : irq_status;
         if (finish_ok) begin
            irq_status[sac_pkg::STAT_DONE_BIT] <= 1'b1;
         end
         if (state == sac_pkg::SAC_FINISH && conversion_done_flag) begin
            irq_status[sac_pkg::STAT_DROP_BIT] <= 1'b1;
         end
      end
   end

   assign irq = (conversion_done_flag && done_irq_enable) || |(irq_status & irq_mask);

   // Converter clock divider, held in reset while powered down.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_cnt       <= '0;
         converter_clk <= 1'b0;
      end else if (!converter_on) begin
         div_cnt       <= '0;
         converter_clk <= 1'b0;
      end else begin
         div_cnt       <= ((div_cnt & div_mask(pre)) == div_mask(pre)) ? '0 : div_cnt + 1'b1;
         converter_clk <= div_cnt[pre];
      end
   end

   assign tick            = converter_on && ((div_cnt & div_mask(pre)) == div_mask(pre));
   assign converter_power = converter_on;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end else begin
         cmp_meta <= cmp_out;
         cmp_sync <= cmp_meta;
      end
   end

   always_comb begin
      next_sar          = sar;
      next_sar[bit_idx] = cmp_sync;
      if (bit_idx != 4'h0) begin
         next_sar[bit_idx - 4'h1] = 1'b1;
      end
      next_acc    = acc + sac_pkg::ACC_W'(next_sar);
      sample_last = (samples + 4'h1) == mean_count(sample_mean_count);
   end

   assign mean       = sac_pkg::RES_W'(acc >> sample_mean_count);
   assign packed_res = pack_result(mean, justify_select);

   // Sequencer: sample, eleven bit decisions per reading, then finish.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state   <= sac_pkg::SAC_IDLE;
         bit_idx <= 4'h0;
         samples <= 4'h0;
         acc     <= '0;
         sar     <= '0;
      end else if (!converter_on) begin
         state <= sac_pkg::SAC_IDLE;
      end else begin
         unique case (state)
            sac_pkg::SAC_IDLE: begin
               if (soft_trigger) begin
                  state   <= sac_pkg::SAC_SAMPLE;
                  samples <= 4'h0;
                  acc     <= '0;
               end
            end
            sac_pkg::SAC_SAMPLE: begin
               if (tick) begin
                  state   <= sac_pkg::SAC_CONVERT;
                  bit_idx <= 4'(sac_pkg::RES_W - 1);
                  sar     <= 11'h400;
               end
            end
            sac_pkg::SAC_CONVERT: begin
               if (tick) begin
                  sar <= next_sar;
                  if (bit_idx == 4'h0) begin
                     acc     <= next_acc;
                     samples <= samples + 4'h1;
                     state   <= sample_last ? sac_pkg::SAC_FINISH : sac_pkg::SAC_SAMPLE;
                  end else begin
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
            sac_pkg::SAC_FINISH: begin
               state <= sac_pkg::SAC_IDLE;
            end
            default: begin
               state <= sac_pkg::SAC_IDLE;
            end
         endcase
      end
   end

   assign sample_hold = (state == sac_pkg::SAC_SAMPLE);
   assign trial_code  = sar;

   // Checks.
   sequence s_finish;
      state == sac_pkg::SAC_FINISH;
   endsequence

   sequence s_fresh_finish;
      s_finish ##0 !conversion_done_flag;
   endsequence

   a_off_stays_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      !converter_on |=> state == sac_pkg::SAC_IDLE && !soft_trigger)
      else $error("converter active while powered down");

   a_div_by_two: assert property (@(posedge mclk) disable iff (!rst_n)
      (tick && pre == 3'h0) ##1 $stable(cfg) ##1 $stable(cfg) |-> !$past(tick) && tick)
      else $error("divide by two spacing wrong");

   a_irq_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      (conversion_done_flag && done_irq_enable) |-> irq)
      else $error("interrupt missing for completion");

   a_irq_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      (!done_irq_enable && (irq_status & irq_mask) == 2'h0) |-> !irq)
      else $error("interrupt raised while disabled");

   a_msb_format: assert property (@(posedge mclk) disable iff (!rst_n)
      s_fresh_finish ##0 justify_select |=> result_low[4:0] == 5'h00 &&
      {result_high, result_low[7:5]} == $past(mean))
      else $error("msb justified layout wrong");

   a_lsb_format: assert property (@(posedge mclk) disable iff (!rst_n)
      s_fresh_finish ##0 !justify_select |=> result_high[7:3] == 5'h00 &&
      {result_high[2:0], result_low} == $past(mean))
      else $error("lsb justified layout wrong");

   a_trigger_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      s_finish |=> !soft_trigger && state == sac_pkg::SAC_IDLE)
      else $error("start bit not cleared at finish");

   a_flag_sets: assert property (@(posedge mclk) disable iff (!rst_n)
      s_fresh_finish |=> conversion_done_flag)
      else $error("completion flag not set");

   a_flag_read_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_acc && addr_idx == sac_pkg::IDX_RES_LOW && snap_flag && !finish_ok)
      |=> !conversion_done_flag)
      else $error("low byte read left flag set");

   a_result_held: assert property (@(posedge mclk) disable iff (!rst_n)
      conversion_done_flag |=> $stable(result_low) && $stable(result_high))
      else $error("result changed while flag set");

   a_results_ro: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_acc && (addr_idx == sac_pkg::IDX_RES_LOW || addr_idx == sac_pkg::IDX_RES_HIGH)
       && !finish_ok) |=> $stable(result_low) && $stable(result_high))
      else $error("write altered a result byte");

   a_sample_total: assert property (@(posedge mclk) disable iff (!rst_n)
      s_finish |-> samples == mean_count(sample_mean_count))
      else $error("wrong number of readings averaged");

endmodule

// ### core/sac_pkg.sv
// Function
// - Converter clock is the system clock divided by 2 up to 256 per divider code.
// - Enable bit 1 runs the converter; 0 holds it powered down with no conversions.
// - Interrupt enable set makes completion raise an interrupt; clear raises none unless a set status bit (0 or 1) is unmasked in the mask register.
// - Format 1: upper eight bits high byte, low three in low bits 7-5, rest zero.
// - Format 0: lower eight bits low byte, top three in high bits 2-0, rest zero.
// - Averaging field 00/01/10/11 selects 1/2/4/8 readings; resets to 00.
// - Input select 00 input A, 01 input B, 10 temperature, 11 supply fifth.
// - Writing 1 to start begins a conversion; hardware clears it when finished.
// - Completion flag sets when a conversion finishes and both result bytes hold it.
// - Reading the low result byte clears the flag; writes to it do nothing.
// - While the flag is set neither result byte takes a newer result.
// - Result bytes are read-only; writes leave them unchanged.
package sac_pkg;
   localparam int          ADDR_W        = 12;
   localparam logic [7:0]  IDX_CONFIG    = 8'ha9;
   localparam logic [7:0]  IDX_RES_LOW   = 8'hba;
   localparam logic [7:0]  IDX_RES_HIGH  = 8'hbb;
   localparam logic [7:0]  IDX_CONTROL   = 8'hce;
   localparam logic [7:0]  IDX_IRQ_STAT  = 8'hd0;
   localparam logic [7:0]  IDX_IRQ_MASK  = 8'hd1;
   localparam logic [7:0]  CONFIG_RESET  = 8'h00;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam int          CFG_ON_BIT    = 7;
   localparam int          CFG_IRQEN_BIT = 6;
   localparam int          CFG_JUST_BIT  = 5;
   localparam int          CFG_PRE_LSB   = 0;
   localparam int          CTL_AVG_LSB   = 6;
   localparam int          CTL_SEL_LSB   = 4;
   localparam int          CTL_FLAG_BIT  = 1;
   localparam int          CTL_TRIG_BIT  = 0;
   localparam int          STAT_DONE_BIT = 0;
   localparam int          STAT_DROP_BIT = 1;
   localparam int          RES_W         = 11;
   localparam int          ACC_W         = 14;
   localparam int          DIV_W         = 8;
   localparam logic [1:0]  SEL_INPUT_A   = 2'h0;
   localparam logic [1:0]  SEL_INPUT_B   = 2'h1;
   localparam logic [1:0]  SEL_TEMP      = 2'h2;
   localparam logic [1:0]  SEL_SUPPLY    = 2'h3;
   localparam int          MCLK_HZ       = 40_000_000;
   localparam int          SETTLE_US     = 20;
   localparam int          SETTLE_CYCLES = (SETTLE_US * (MCLK_HZ / 1_000_000));
   typedef enum logic [3:0] {
      SAC_IDLE    = 4'h1,
      SAC_SAMPLE  = 4'h2,
      SAC_CONVERT = 4'h4,
      SAC_FINISH  = 4'h8
   } sac_state_e;
endpackage

// ### dv/sac_analog_model.sv
module sac_analog_model (
   input  wire logic             mclk,
   input  wire logic             clr,
   input  wire logic             converter_power,
   input  wire logic [1:0]       input_select,
   input  wire logic             sample_hold,
   input  wire logic [10:0]      trial_code,
   input  wire logic [3:0][10:0] lvl,
   output logic                  cmp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  n_rd = 4'h0;
   logic        hold_d = 1'b0;
   logic        last = 1'b0;
   logic [11:0] v;
   // Each reading sees its level plus a running count, so averaging shows in the result.
   always_ff @(posedge mclk) begin
      hold_d <= sample_hold;
      last   <= cmp_out;
      if (clr) begin
         n_rd <= 4'h0;
      end else if (hold_d && !sample_hold) begin
         n_rd <= n_rd + 4'h1;
      end
   end
   assign v = {1'b0, lvl[input_select]} + {8'h00, n_rd};
   // A powered-down comparator toggles instead of holding its last answer.
   assign cmp_out = converter_power ? (v >= {1'b0, trial_code}) : ~last;
endmodule

// ### dv/sar_adc_control_tb.sv
module sar_adc_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic             mclk = 1'b0;
   logic             rst_n = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [11:0]      paddr = 12'h000;
   logic [31:0]      pwdata = 32'h0;
   logic [3:0]       pstrb = 4'hf;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             irq;
   logic             converter_power;
   logic             converter_clk;
   logic [1:0]       input_select;
   logic             sample_hold;
   logic [10:0]      trial_code;
   logic             cmp_out;
   logic             clr = 1'b0;
   logic [3:0][10:0] lvl = '0;
   logic [33:0]      exp_q[$];
   logic [33:0]      e;
   logic [7:0]       rd;
   int               n_mismatch = 0;
   int               check_count = 0;
   longint           t0;
   always #12.5 mclk = ~mclk;
   sac_top sac_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .converter_power(converter_power),
      .converter_clk(converter_clk), .input_select(input_select),
      .sample_hold(sample_hold), .trial_code(trial_code), .cmp_out(cmp_out));
   sac_analog_model sac_analog_model_inst (.mclk(mclk), .clr(clr),
      .converter_power(converter_power), .input_select(input_select),
      .sample_hold(sample_hold), .trial_code(trial_code), .lvl(lvl), .cmp_out(cmp_out));
   task automatic check(input string nm, input logic [32:0] ex, input logic [32:0] got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Each completed transfer is judged against the oldest note.
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("queue", 33'h0, 33'h1);
         end else begin
            e = exp_q.pop_front();
            if (e[33]) begin
               check("read", e[32:0], {pslverr, prdata});
            end else begin
               check("pslverr", {32'h0, e[32]}, {32'h0, pslverr});
            end
         end
      end
   end
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      input logic chk, input logic [7:0] ex, input logic err);
      exp_q.push_back({chk, err, 24'h0, ex});
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h0, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd, 1'b0, 8'h00, 1'b0);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex);
      apb(1'b0, idx, 8'h00, 1'b1, ex, 1'b0);
   endtask
   task automatic poll(input int b, input logic val);
      int n;
      n = 0;
      do begin
         apb(1'b0, sac_pkg::IDX_CONTROL, 8'h00, 1'b0, 8'h00, 1'b0);
         n++;
      end while (rd[b] !== val && n < 400);
      check("poll", {32'h0, val}, {32'h0, rd[b]});
   endtask
   task automatic start_run(input logic [1:0] sel, input logic [1:0] avg);
      @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      wr_reg(sac_pkg::IDX_CONTROL, {avg, sel, 4'h1});
   endtask
   task automatic conv(input logic [1:0] sel, input logic [1:0] avg, input logic just,
                       input logic ie);
      logic [13:0] sum;
      logic [10:0] r;
      wr_reg(sac_pkg::IDX_CONFIG, {1'b1, ie, just, 5'h01});
      sum = 14'h0;
      for (int k = 1; k <= (1 << avg); k++) sum += 14'(lvl[sel]) + 14'(k);
      r = 11'(sum >> avg);
      start_run(sel, avg);
      poll(sac_pkg::CTL_FLAG_BIT, 1'b1);
      check("start bit", 33'h0, {32'h0, rd[0]});
      check("irq set", {32'h0, ie}, {32'h0, irq});
      wr_reg(sac_pkg::IDX_RES_HIGH, 8'h55);
      wr_reg(sac_pkg::IDX_RES_LOW, 8'haa);
      rd_chk(sac_pkg::IDX_RES_HIGH, just ? r[10:3] : {5'h0, r[10:8]});
      rd_chk(sac_pkg::IDX_RES_LOW, just ? {r[2:0], 5'h0} : r[7:0]);
      rd_chk(sac_pkg::IDX_CONTROL, {avg, sel, 4'h0});
      @(negedge mclk);
      check("irq clear", 33'h0, {32'h0, irq});
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hb0ab));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd_chk(sac_pkg::IDX_CONFIG, sac_pkg::CONFIG_RESET);
      rd_chk(sac_pkg::IDX_CONTROL, sac_pkg::CONTROL_RESET);
      check("irq reset", 33'h0, {32'h0, irq});
      wr_reg(sac_pkg::IDX_CONFIG, 8'h7f);
      rd_chk(sac_pkg::IDX_CONFIG, 8'h67);
      wr_reg(sac_pkg::IDX_CONTROL, 8'h02);
      rd_chk(sac_pkg::IDX_CONTROL, 8'h00);
      apb(1'b0, 8'h10, 8'h00, 1'b1, 8'h00, 1'b1);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         wr_reg(sac_pkg::IDX_CONFIG, 8'h80 | 8'(c));
         repeat (2) @(posedge converter_clk);
         t0 = $time;
         @(posedge converter_clk);
         check("divider", 33'(1 << (c + 1)), 33'(($time - t0) / 25));
      end
      wr_reg(sac_pkg::IDX_CONFIG, 8'h00);
      repeat (4) @(posedge mclk);
      check("power off", 33'h0, {31'h0, converter_power, converter_clk});
      wr_reg(sac_pkg::IDX_CONFIG, 8'h81);
      start_run(2'h0, 2'h3);
      wr_reg(sac_pkg::IDX_CONFIG, 8'h01);
      rd_chk(sac_pkg::IDX_CONTROL, 8'hc0);
      $display("test clock and power done");
      wr_reg(sac_pkg::IDX_CONFIG, 8'h81);
      repeat (sac_pkg::SETTLE_CYCLES) @(posedge mclk);
      for (int i = 0; i < 16; i++) begin
         for (int j = 0; j < 4; j++) lvl[j] <= 11'($urandom_range(0, 2000));
         conv(2'(i), 2'(i >> 2), i[0] ^ i[2], i[1]);
      end
      $display("test conversions done");
      wr_reg(sac_pkg::IDX_IRQ_MASK, 8'h02);
      apb(1'b0, sac_pkg::IDX_IRQ_STAT, 8'h00, 1'b0, 8'h00, 1'b0);
      wr_reg(sac_pkg::IDX_CONFIG, 8'h81);
      lvl[0] <= 11'h123;
      start_run(2'h0, 2'h0);
      poll(sac_pkg::CTL_FLAG_BIT, 1'b1);
      check("irq masked", 33'h0, {32'h0, irq});
      lvl[0] <= 11'h6dc;
      start_run(2'h0, 2'h0);
      poll(sac_pkg::CTL_TRIG_BIT, 1'b0);
      check("irq drop", 33'h1, {32'h0, irq});
      rd_chk(sac_pkg::IDX_IRQ_STAT, 8'h03);
      @(negedge mclk);
      check("irq cleared", 33'h0, {32'h0, irq});
      rd_chk(sac_pkg::IDX_RES_HIGH, 8'h01);
      rd_chk(sac_pkg::IDX_RES_LOW, 8'h24);
      $display("test held result done");
      repeat (4) @(posedge mclk);
      give_verdict();
   end
endmodule
